/* dap_nm_div.sv */
// Fractional N/M clock-enable divider
`timescale 1ns/1ps
`default_nettype none

module dap_nm_div
	import dap_pkg::*;
(
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_en,
	input  wire logic [ACC_W-1:0] i_step,
	input  wire logic [ACC_W-1:0] i_mod,
	output var  logic             o_tick
);

	// ==========================================================
	// Accumulator
	logic [ACC_W:0]   sum;
	logic [ACC_W-1:0] acc_ff;
	logic [ACC_W-1:0] nxt_acc;
	logic             tick_ff;
	logic             nxt_tick;

	// Add N each cycle, pay out M with one tick; ticks spread evenly
	always_comb begin
		sum      = {1'b0, acc_ff} + {1'b0, i_step};
		nxt_acc  = acc_ff;
		nxt_tick = 1'b0;
		if (!i_en) begin
			nxt_acc = '0;  // Restart cleanly on mode change
		end else if (sum >= {1'b0, i_mod}) begin
			nxt_acc  = ACC_W'(sum - {1'b0, i_mod});
			nxt_tick = 1'b1;
		end else begin
			nxt_acc = sum[ACC_W-1:0];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			acc_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			acc_ff  <= nxt_acc;
			tick_ff <= nxt_tick;
		end
	end

	assign o_tick = tick_ff;

endmodule

`default_nettype wire

/* dap_peer_model.sv */
// Far-side audio peer: clocks slave ports, echoes data back
`timescale 1ns/1ps
`default_nettype none

module dap_peer_model
	import dap_pkg::*;
(
	input  wire logic                         i_core_clk,
	input  wire logic                         i_rst_n,
	input  wire logic [3:0]                   i_half,
	input  wire dap_pin_out_s [NUM_PORTS-1:0] i_dev,
	output var  dap_pin_in_s  [NUM_PORTS-1:0] o_pin
);
	logic [3:0] cnt;
	logic [3:0] bits;
	logic       sck;
	logic       ws;

	// ========
	// Bit clock of i_half+1 cycles a phase; ws moves on falls
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			{cnt, bits, sck, ws} <= '0;
		end else if (cnt != i_half) begin
			cnt <= cnt + 4'h1;
		end else begin
			cnt <= '0;
			sck <= !sck;
			bits <= bits + {3'h0, sck};  // Falls counted, 16 a word
			ws <= ws ^ (sck && bits == 4'hF);
		end
	end

	// Wire level: device wins where it drives; data echoed back
	always_comb begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			o_pin[p].sck = i_dev[p].sck_oe_n ? sck : i_dev[p].sck;
			o_pin[p].ws = i_dev[p].ws_oe_n ? ws : i_dev[p].ws;
			o_pin[p].sdi = i_dev[p].sdo;
		end
	end
endmodule
`default_nettype wire

/* dap_pkg.sv */
// Shared constants and carrier types for the dual serial audio port block
package dap_pkg;

	// ==========================================================
	// Port count and word geometry
	localparam int unsigned NUM_PORTS = 2;
	localparam int unsigned WORD_W    = 16;
	localparam logic [4:0]  WORD_BITS = 5'h10;  // Data bits per channel slot

	// ==========================================================
	// Master-mode frame geometry (bit clocks per frame and per slot)
	localparam logic [5:0] FRAME_LEN_32 = 6'h20;
	localparam logic [5:0] FRAME_LEN_50 = 6'h32;
	localparam logic [5:0] SLOT_LEN_32  = 6'h10;
	localparam logic [5:0] SLOT_LEN_50  = 6'h19;

	// ==========================================================
	// Timing: core clock and target rates in kHz
	localparam int unsigned CORE_CLK_KHZ = 20000;
	localparam int unsigned FRAME_KHZ    = 48;
	localparam int unsigned BCLK_32_KHZ  = FRAME_KHZ * 32;  // 1536 kHz
	localparam int unsigned BCLK_50_KHZ  = FRAME_KHZ * 50;  // 2400 kHz
	localparam int unsigned SLAVE_MAX_KHZ = 3072;            // Peer bit clock ceiling
	localparam real         DUTY_MIN     = 0.35;             // Least phase share of period

	// ==========================================================
	// N/M divider: half-period ticks at twice the bit clock rate
	localparam int unsigned ACC_W = 12;
	localparam int unsigned GCD_32 = 32;
	localparam int unsigned GCD_50 = 800;
	localparam logic [ACC_W-1:0] DIV_N_32 = ACC_W'(2 * BCLK_32_KHZ / GCD_32);
	localparam logic [ACC_W-1:0] DIV_M_32 = ACC_W'(CORE_CLK_KHZ / GCD_32);
	localparam logic [ACC_W-1:0] DIV_N_50 = ACC_W'(2 * BCLK_50_KHZ / GCD_50);
	localparam logic [ACC_W-1:0] DIV_M_50 = ACC_W'(CORE_CLK_KHZ / GCD_50);

	// ==========================================================
	// Reset values
	localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic sck;
		logic ws;
		logic sdi;
	} dap_pin_in_s;

	typedef struct packed {
		logic sck;
		logic sck_oe_n;
		logic ws;
		logic ws_oe_n;
		logic sdo;
	} dap_pin_out_s;

	typedef struct packed {
		logic [WORD_W-1:0] left;
		logic [WORD_W-1:0] right;
	} dap_stereo_s;

	typedef struct packed {
		logic master;
		logic frame50;
	} dap_cfg_s;

	// Per-port engine state
	typedef struct packed {
		logic              sck;
		logic              ws;
		logic              sdo;
		logic              oe_n;
		logic              sck_prev;
		logic              ws_smp;
		logic              ws_last;
		logic [5:0]        bit_cnt;
		logic [WORD_W-1:0] tx_sh;
		logic [4:0]        tx_cnt;
		logic [WORD_W-1:0] tx_hold;
		logic              tx_take;
		logic [WORD_W-1:0] rx_sh;
		logic [4:0]        rx_cnt;
		logic              rx_ch;
		logic [WORD_W-1:0] rx_left;
		dap_stereo_s       rx;
		logic              rx_valid;
	} dap_port_st_s;

endpackage

/* dap_top.sv */
// Dual serial stereo audio port, master or slave per port
//
// How it works
// - Two independent ports, each with own pins
// - Each port selects master or slave role
// - Master drives clock/select; output always driven
// - Every channel word carries sixteen bits
// - Left word MSB leads each frame
// - MSB follows word-select change by one clock
// - Select low is left, high is right
// - Output changes on falling, peer samples rising
// - Master frame 48 kHz, 32 or 50 clocks
// - Master bit clock from N/M divider
// - Slave takes any peer clock up to 3.072 MHz
// - Master clock phases each at least 0.35T
`timescale 1ns/1ps
`default_nettype none

module dap_top
	import dap_pkg::*;
(
	input  wire logic                          i_core_clk,
	input  wire logic                          i_rst_n,
	input  wire dap_cfg_s     [NUM_PORTS-1:0]  i_cfg,
	input  wire dap_pin_in_s  [NUM_PORTS-1:0]  i_pin,
	input  wire dap_stereo_s  [NUM_PORTS-1:0]  i_tx,
	output var  dap_pin_out_s [NUM_PORTS-1:0]  o_pin,
	output var  logic         [NUM_PORTS-1:0]  o_tx_take,
	output var  dap_stereo_s  [NUM_PORTS-1:0]  o_rx,
	output var  logic         [NUM_PORTS-1:0]  o_rx_valid
);

	// ==========================================================
	// One engine per port; no state is shared between ports
	genvar g;
	generate
		for (g = 0; g < NUM_PORTS; g++) begin : g_port
			dap_port_st_s     st_ff;
			dap_port_st_s     nxt_st;
			logic             tick;
			logic             ev_rise;
			logic             ev_fall;
			logic             ws_line;
			logic [ACC_W-1:0] div_n;
			logic [ACC_W-1:0] div_m;

			// Divider ratio follows the frame-length choice
			assign div_n = i_cfg[g].frame50 ? DIV_N_50 : DIV_N_32;
			assign div_m = i_cfg[g].frame50 ? DIV_M_50 : DIV_M_32;

			// Half-period ticks; toggling on them keeps each phase at least 0.46T in 32-clock frames, 0.44T (4 of 9 cycles) in 50-clock frames
			dap_nm_div u_div (
				.i_core_clk (i_core_clk),
				.i_rst_n    (i_rst_n),
				.i_en       (i_cfg[g].master),
				.i_step     (div_n),
				.i_mod      (div_m),
				.o_tick     (tick)
			);

			// Bit clock edges: own toggles in master, pin transitions in slave
			assign ev_rise = i_cfg[g].master ? (tick & ~st_ff.sck)
				: (~st_ff.sck_prev & i_pin[g].sck);
			assign ev_fall = i_cfg[g].master ? (tick & st_ff.sck)
				: (st_ff.sck_prev & ~i_pin[g].sck);
			// Word select as seen on the wire, whoever drives it
			assign ws_line = i_cfg[g].master ? st_ff.ws : i_pin[g].ws;

			// Next-state logic for clock, framing, transmit and receive
			always_comb begin
				nxt_st          = st_ff;
				nxt_st.tx_take  = 1'b0;
				nxt_st.rx_valid = 1'b0;
				nxt_st.oe_n     = ~i_cfg[g].master;
				nxt_st.sck_prev = i_pin[g].sck;

				// Master clock and frame counter; slave holds them idle
				if (i_cfg[g].master) begin
					if (tick) begin
						nxt_st.sck = ~st_ff.sck;
					end
					if (ev_fall) begin
						if (6'(st_ff.bit_cnt + 6'h01)
							>= (i_cfg[g].frame50 ? FRAME_LEN_50 : FRAME_LEN_32)) begin
							nxt_st.bit_cnt = 6'h00;
						end else begin
							nxt_st.bit_cnt = 6'(st_ff.bit_cnt + 6'h01);
						end
						// First half of frame is left (low), second right (high)
						nxt_st.ws = (nxt_st.bit_cnt
							>= (i_cfg[g].frame50 ? SLOT_LEN_50 : SLOT_LEN_32));
					end
				end else begin
					nxt_st.sck     = 1'b0;
					nxt_st.ws      = 1'b0;
					nxt_st.bit_cnt = 6'h00;
				end

				// Receive side: capture on rising edges only
				if (ev_rise) begin
					nxt_st.ws_smp = ws_line;
					if (st_ff.rx_cnt < WORD_BITS) begin
						nxt_st.rx_sh  = {st_ff.rx_sh[WORD_W-2:0], i_pin[g].sdi};
						nxt_st.rx_cnt = 5'(st_ff.rx_cnt + 5'h01);
						if (st_ff.rx_cnt == 5'(WORD_BITS - 5'h01)) begin
							if (!st_ff.rx_ch) begin
								nxt_st.rx_left = nxt_st.rx_sh;
							end else begin
								nxt_st.rx.left  = st_ff.rx_left;
								nxt_st.rx.right = nxt_st.rx_sh;
								nxt_st.rx_valid = 1'b1;
							end
						end
					end
					// A select change starts a new word count
					if (ws_line != st_ff.ws_smp) begin
						nxt_st.rx_cnt = 5'h00;
						nxt_st.rx_ch  = ws_line;
					end
				end

				// Transmit side: drive only on falling edges
				if (ev_fall) begin
					nxt_st.ws_last = st_ff.ws_smp;
					if (st_ff.ws_smp != st_ff.ws_last) begin
						// One clock after the select change: MSB goes out
						if (!st_ff.ws_smp) begin
							nxt_st.sdo     = i_tx[g].left[WORD_W-1];
							nxt_st.tx_sh   = {i_tx[g].left[WORD_W-2:0], 1'b0};
							nxt_st.tx_hold = i_tx[g].right;
							nxt_st.tx_take = 1'b1;
						end else begin
							nxt_st.sdo   = st_ff.tx_hold[WORD_W-1];
							nxt_st.tx_sh = {st_ff.tx_hold[WORD_W-2:0], 1'b0};
						end
						nxt_st.tx_cnt = 5'h01;
					end else if (st_ff.tx_cnt < WORD_BITS) begin
						nxt_st.sdo    = st_ff.tx_sh[WORD_W-1];
						nxt_st.tx_sh  = {st_ff.tx_sh[WORD_W-2:0], 1'b0};
						nxt_st.tx_cnt = 5'(st_ff.tx_cnt + 5'h01);
					end else begin
						nxt_st.sdo = 1'b0;
					end
				end
			end

			// State register
			always_ff @(posedge i_core_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					st_ff <= '{
						sck: 1'b0, ws: 1'b0, sdo: 1'b0, oe_n: 1'b1,
						sck_prev: 1'b0, ws_smp: 1'b0, ws_last: 1'b0,
						bit_cnt: 6'h00, tx_sh: WORD_RST, tx_cnt: WORD_BITS,
						tx_hold: WORD_RST, tx_take: 1'b0, rx_sh: WORD_RST,
						rx_cnt: WORD_BITS, rx_ch: 1'b0, rx_left: WORD_RST,
						rx: '{left: WORD_RST, right: WORD_RST}, rx_valid: 1'b0};
				end else begin
					st_ff <= nxt_st;
				end
			end

			// Pins and user outputs come straight from the state register
			assign o_pin[g].sck      = st_ff.sck;
			assign o_pin[g].sck_oe_n = st_ff.oe_n;
			assign o_pin[g].ws       = st_ff.ws;
			assign o_pin[g].ws_oe_n  = st_ff.oe_n;
			assign o_pin[g].sdo      = st_ff.sdo;
			assign o_tx_take[g]      = st_ff.tx_take;
			assign o_rx[g]           = st_ff.rx;
			assign o_rx_valid[g]     = st_ff.rx_valid;
		end
	endgenerate

endmodule

`default_nettype wire

/* dap_top_asserts.sv */
// Concurrent checks on the pins and user outputs of the dual audio port
`timescale 1ns/1ps
`default_nettype none

module dap_top_asserts
	import dap_pkg::*;
(
	input  wire logic                         i_core_clk,
	input  wire logic                         i_rst_n,
	input  wire dap_cfg_s     [NUM_PORTS-1:0] i_cfg,
	input  wire dap_pin_in_s  [NUM_PORTS-1:0] i_pin,
	input  wire dap_pin_out_s [NUM_PORTS-1:0] o_pin,
	input  wire logic         [NUM_PORTS-1:0] o_tx_take,
	input  wire dap_stereo_s  [NUM_PORTS-1:0] o_rx,
	input  wire logic         [NUM_PORTS-1:0] o_rx_valid
);
	// ========
	// One domain, so clocking and reset are given once
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// ========
	// Per port; clock checks only hold while the port drives its clock
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		a_oe_role: assert property (
			$past(i_rst_n) |-> o_pin[p].sck_oe_n == !$past(i_cfg[p].master))
			else $error("clock drive enable disagrees with role");
		a_ws_oe_pair: assert property (
			o_pin[p].ws_oe_n == o_pin[p].sck_oe_n)
			else $error("select and clock drive enables differ");
		a_sdo_on_fall: assert property (
			!o_pin[p].sck_oe_n && $changed(o_pin[p].sdo) |-> $fell(o_pin[p].sck))
			else $error("data moved off a falling clock");
		a_sdo_slave_fall: assert property (
			o_pin[p].sck_oe_n && $changed(o_pin[p].sdo)
				|-> $past(i_pin[p].sck, 2) && !$past(i_pin[p].sck))
			else $error("slave data moved off a peer falling clock");
		a_ws_on_fall: assert property (
			!o_pin[p].sck_oe_n && $changed(o_pin[p].ws) |-> $fell(o_pin[p].sck))
			else $error("select moved off a falling clock");
		a_phase_min: assert property (
			!o_pin[p].sck_oe_n && $changed(o_pin[p].sck) |=> $stable(o_pin[p].sck)[*2])
			else $error("bit clock phase too short");
		a_phase_max: assert property (
			!o_pin[p].sck_oe_n && $changed(o_pin[p].sck) |-> ##[1:7] $changed(o_pin[p].sck))
			else $error("bit clock phase too long");
		a_take_left: assert property (
			o_tx_take[p] && !o_pin[p].sck_oe_n |-> !o_pin[p].ws ##1 !o_tx_take[p])
			else $error("frame taken outside left slot");
		a_rx_hold: assert property (
			!o_rx_valid[p] |-> $stable(o_rx[p]))
			else $error("received frame moved without valid");
	end
endmodule

bind dap_top dap_top_asserts u_chk (
	.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n),
	.i_cfg(i_cfg),
	.i_pin(i_pin),
	.o_pin(o_pin),
	.o_tx_take(o_tx_take),
	.o_rx(o_rx),
	.o_rx_valid(o_rx_valid)
);
`default_nettype wire

/* test_dual_i2s_audio_port.sv */
// Loopback bench over both roles and frame lengths
`timescale 1ns/1ps
`default_nettype none

module test_dual_i2s_audio_port
	import dap_pkg::*;
;
	logic                         i_core_clk = 1'b0;
	logic                         i_rst_n = 1'b0;
	dap_cfg_s     [NUM_PORTS-1:0] i_cfg = '0;
	dap_stereo_s  [NUM_PORTS-1:0] i_tx = '0;
	dap_pin_in_s  [NUM_PORTS-1:0] i_pin;
	dap_pin_out_s [NUM_PORTS-1:0] o_pin;
	logic         [NUM_PORTS-1:0] o_tx_take;
	logic         [NUM_PORTS-1:0] o_rx_valid;
	dap_stereo_s  [NUM_PORTS-1:0] o_rx;
	dap_stereo_s  [NUM_PORTS-1:0] exp_rx;
	logic         [3:0]           half = 4'h3;
	integer                       seed = 32'hCD07D68C;
	int                           n_fail = 0;
	int                           comparisons = 0;
	int                           ntake [NUM_PORTS];
	int                           nrx [NUM_PORTS];
	int                           gap [NUM_PORTS];

	dap_top u_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_cfg(i_cfg),
		.i_pin(i_pin), .i_tx(i_tx), .o_pin(o_pin), .o_tx_take(o_tx_take),
		.o_rx(o_rx), .o_rx_valid(o_rx_valid));
	dap_peer_model u_peer (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_half(half), .i_dev(o_pin), .o_pin(i_pin));

	// ========
	// 20 MHz core clock
	initial begin
		forever #25 i_core_clk = !i_core_clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", what, exp, got);
		end
	endtask

	// Frame spacing: master 20 MHz / 48 kHz, slave 64 peer phases
	function automatic int gap_err(input logic master, input int g);
		if (master)
			return (g == 416 || g == 417) ? 0 : g;
		return (g == 64 * (half + 1)) ? 0 : g;
	endfunction

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Take frames, refill at random, check echoes and spacing
	always @(negedge i_core_clk) begin
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (i_rst_n !== 1'b1) begin
				{ntake[p], nrx[p], gap[p]} = '0;
			end else begin
				gap[p]++;
				if (o_rx_valid[p] === 1'b1 && ntake[p] > 0) begin
					nrx[p]++;
					chk("rx frame", exp_rx[p], o_rx[p]);
				end
				if (o_tx_take[p] === 1'b1) begin
					if (ntake[p] > 0)
						chk("frame gap", 32'h0, gap_err(i_cfg[p].master, gap[p]));
					ntake[p]++;
					gap[p] = 0;
					exp_rx[p] = i_tx[p];
					i_tx[p] = dap_stereo_s'($random(seed));
				end
			end
		end
	end

	// Phases: master 32 + fast slave, slow slave + master 50, two masters
	initial begin
		for (int ph = 0; ph < 3; ph++) begin
			i_rst_n = 1'b0;
			i_cfg = (ph == 0) ? 4'h2 : (ph == 1) ? 4'hC : 4'hB;
			half = (ph == 1) ? 4'hB : 4'h3;
			i_tx = {16'h8000, 16'h0001, 16'hFFFF, 16'h7FFE};
			repeat (10) @(negedge i_core_clk);
			i_rst_n = 1'b1;
			repeat (2) @(negedge i_core_clk);
			for (int p = 0; p < NUM_PORTS; p++)
				chk("sck oe_n", 32'(!i_cfg[p].master), 32'(o_pin[p].sck_oe_n));
			repeat (6000) @(negedge i_core_clk);
			for (int p = 0; p < NUM_PORTS; p++)
				chk("rx count ok", 32'h1, 32'(nrx[p] >= 3));
			$display("phase %0d done", ph);
		end
		tally_and_finish();
	end

	// Watchdog well past the expected 18k cycles
	initial begin
		repeat (30000) @(posedge i_core_clk);
		n_fail++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
